// ---- design/dcf_pkg.sv ----
// constants, types and helpers for the dual-clock fifo flag block
// ----------------------------------------------------------------
// Summary of operation
// - every flag passes a two-stage synchroniser on its own port clock
// - ready-out and almost-empty on reader clock; ready-in and almost-full on writer
// - output ready high means unread word held; low holds old word, ignores reads
// - read pointer steps once per word moved into the output register
// - new word visible on third reader edge, loaded with output ready together
// - reader edge too close after a write does not start the count
// - input ready high means a free slot; low means full, in reset or held for programming, writes ignored
// - write pointer steps once per stored word; offset-programming writes do not step it
// - slot freed by a read is writable on the second writer edge
// - writer edge too close after a read does not start the count
// - almost-empty low at offset words or fewer, high above
// - word in output register counts as read; its slot is free
// - almost-empty rises on second reader edge after the filling write
// - almost-full low at depth minus offset or more, high below
// - almost-full rises on second writer edge after the draining read
// - flag comparisons use the stored per-fifo offsets
// - at fifo reset release selects pick preset 64, 16 or 8
// - both selects low at release of both fifo resets together: first four port-a writes load full1, empty1, full2, empty2 offsets
// ----------------------------------------------------------------
package dcf_pkg;
    localparam int DATA_W = 36;
    localparam int DEPTH = 512;
    localparam int OFFSET_W = 9;
    localparam int SYNC_STAGES = 2;
    localparam int OFFSET_MAX = 508;
    localparam logic [8:0] PRESET_BOTH = 9'h040;
    localparam logic [8:0] PRESET_HIGH = 9'h010;
    localparam logic [8:0] PRESET_LOW = 9'h008;
    localparam logic [8:0] OFFSET_RESET = 9'h008;

    typedef enum logic [2:0] {
        PROG_IDLE,
        PROG_FULL1,
        PROG_EMPTY1,
        PROG_FULL2,
        PROG_EMPTY2
    } dcf_prog_e;

    typedef struct packed {
        logic out_ready;
        logic almost_empty_n;
        logic in_ready;
        logic almost_full_n;
    } dcf_flags_s;

    function automatic logic [9:0] bin2gray(input logic [9:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [9:0] gray2bin(input logic [9:0] g);
        logic [9:0] b;
        b[9] = g[9];
        for (int i = 8; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray2bin
endpackage : dcf_pkg

// ---- design/dcf_top.sv ----
// one fifo direction plus the offset registers and the two-fifo top
`timescale 1ns/1ps

// ----------------------------------------------------------------
// one direction: writer ticks and reader ticks stand for port clock edges
// ----------------------------------------------------------------
module dcf_fifo #(
    parameter int DW = dcf_pkg::DATA_W,
    parameter int DEPTH = dcf_pkg::DEPTH
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic wr_tick_i,
    input wire logic rd_tick_i,
    input wire logic wr_req_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic wr_store_i,
    input wire logic ir_hold_i,
    input wire logic rd_req_i,
    input wire logic [8:0] ae_off_i,
    input wire logic [8:0] af_off_i,
    output logic [DW-1:0] rd_data_o,
    output dcf_pkg::dcf_flags_s flags_o,
    output logic wr_take_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [9:0] DEPTH_V = 10'(DEPTH);

    if (AW != 9 || DEPTH != (1 << AW)) begin : g_check
        $error("depth must be 512");
    end

    logic [DW-1:0] mem [DEPTH];
    logic [9:0] wptr, wgray, rs1, rs2, next_wptr, next_wgray, next_rs1, next_rs2;
    logic [9:0] rptr, rgray, ws1, ws2, next_rptr, next_rgray, next_ws1, next_ws2;
    logic or_q, next_or;
    logic [DW-1:0] dout, next_dout;
    logic [9:0] wfill, rfill;
    logic ir, store, avail, load;

    // ----------------------------------------------------------------
    // writer side
    // ----------------------------------------------------------------
    always_comb begin
        wfill = wptr - dcf_pkg::gray2bin(rs2);
        ir = run_i && !ir_hold_i && (wfill != DEPTH_V);
        wr_take_o = wr_tick_i && wr_req_i && ir;
        store = wr_take_o && wr_store_i;
        next_wptr = wptr;
        next_wgray = wgray;
        next_rs1 = rs1;
        next_rs2 = rs2;
        if (!run_i) begin
            next_wptr = '0;
            next_wgray = '0;
            next_rs1 = '0;
            next_rs2 = '0;
        end else if (wr_tick_i) begin
            next_rs1 = rgray;
            next_rs2 = rs1;
            if (store) begin
                next_wptr = wptr + 10'h001;
                next_wgray = dcf_pkg::bin2gray(wptr + 10'h001);
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wptr <= '0;
            wgray <= '0;
            rs1 <= '0;
            rs2 <= '0;
        end else begin
            wptr <= next_wptr;
            wgray <= next_wgray;
            rs1 <= next_rs1;
            rs2 <= next_rs2;
        end
    end

    always_ff @(posedge clock_i) begin
        if (store) begin
            mem[wptr[AW-1:0]] <= wr_data_i;
        end
    end

    // ----------------------------------------------------------------
    // reader side
    // ----------------------------------------------------------------
    always_comb begin
        rfill = dcf_pkg::gray2bin(ws2) - rptr;
        avail = rfill != 10'h000;
        load = rd_tick_i && avail && (!or_q || rd_req_i);
        next_rptr = rptr;
        next_rgray = rgray;
        next_ws1 = ws1;
        next_ws2 = ws2;
        next_or = or_q;
        next_dout = dout;
        if (!run_i) begin
            next_rptr = '0;
            next_rgray = '0;
            next_ws1 = '0;
            next_ws2 = '0;
            next_or = 1'b0;
        end else if (rd_tick_i) begin
            next_ws1 = wgray;
            next_ws2 = ws1;
            if (load) begin
                next_dout = mem[rptr[AW-1:0]];
                next_rptr = rptr + 10'h001;
                next_rgray = dcf_pkg::bin2gray(rptr + 10'h001);
                next_or = 1'b1;
            end else if (rd_req_i) begin
                next_or = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rptr <= '0;
            rgray <= '0;
            ws1 <= '0;
            ws2 <= '0;
            or_q <= 1'b0;
            dout <= '0;
        end else begin
            rptr <= next_rptr;
            rgray <= next_rgray;
            ws1 <= next_ws1;
            ws2 <= next_ws2;
            or_q <= next_or;
            dout <= next_dout;
        end
    end

    // flags other than output ready follow the second stage directly so they move on the second edge
    always_comb begin
        flags_o.out_ready = or_q;
        flags_o.almost_empty_n = run_i && (rfill > {1'b0, ae_off_i});
        flags_o.in_ready = ir;
        flags_o.almost_full_n = !run_i
            || (wfill <= (DEPTH_V - 10'h001 - {1'b0, af_off_i}));
        rd_data_o = dout;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_load;
        run_i && load;
    endsequence
    sequence s_refused_read;
        run_i && rd_tick_i && rd_req_i && !or_q && !avail;
    endsequence

    AST_LOAD_STEP: assert property (s_load |=> or_q && rptr == $past(rptr) + 10'h001)
        else $error("load did not step read pointer and raise ready");
    AST_LOAD_DATA: assert property (s_load |=> dout == $past(mem[rptr[AW-1:0]]))
        else $error("output register not loaded from memory");
    AST_READ_IGNORED: assert property (s_refused_read |=> !or_q && $stable(dout))
        else $error("read taken while output not ready");
    AST_WRITE_IGNORED: assert property (
        run_i && wr_tick_i && wr_req_i && wfill == DEPTH_V |=> $stable(wptr))
        else $error("write taken while full");
    AST_WPTR_STEP: assert property (run_i && store |=> wptr == $past(wptr) + 10'h001)
        else $error("write pointer did not step");
    AST_SYNC_CHAIN: assert property (
        run_i && rd_tick_i ##1 run_i && rd_tick_i |=> ws2 == $past(wgray, 2))
        else $error("gray pointer not carried two stages");
    AST_RESET_FLAGS: assert property (
        !run_i |-> !flags_o.in_ready && flags_o.almost_full_n && !flags_o.almost_empty_n
            ##1 !or_q)
        else $error("held fifo not shown empty");
    AST_FULL_ALMOST: assert property (
        run_i && wfill == DEPTH_V |-> !flags_o.almost_full_n && !flags_o.in_ready)
        else $error("full fifo not flagged almost full");
    AST_EMPTY_LEVEL: assert property (
        run_i && !avail |-> !flags_o.almost_empty_n)
        else $error("empty fifo shows above almost-empty offset");
endmodule : dcf_fifo

// ----------------------------------------------------------------
// top: fifo1 port a to port b, fifo2 port b to port a, offset registers
// ----------------------------------------------------------------
module dcf_top #(
    parameter int DW = dcf_pkg::DATA_W
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic port_a_clock_i,
    input wire logic port_b_clock_i,
    input wire logic fifo1_reset_n_i,
    input wire logic fifo2_reset_n_i,
    input wire logic offset_select_low_i,
    input wire logic offset_select_high_i,
    input wire logic port_a_write_i,
    input wire logic port_a_read_i,
    input wire logic [DW-1:0] port_a_data_i,
    input wire logic port_b_write_i,
    input wire logic port_b_read_i,
    input wire logic [DW-1:0] port_b_data_i,
    output logic [DW-1:0] port_a_data_o,
    output logic [DW-1:0] port_b_data_o,
    output logic port_a_output_ready_o,
    output logic port_a_almost_empty_n_o,
    output logic port_a_input_ready_o,
    output logic port_a_almost_full_n_o,
    output logic port_b_output_ready_o,
    output logic port_b_almost_empty_n_o,
    output logic port_b_input_ready_o,
    output logic port_b_almost_full_n_o
);
    dcf_pkg::dcf_flags_s f1, f2;
    dcf_pkg::dcf_prog_e prog, next_prog;
    logic [8:0] fifo1_empty_offset, fifo1_full_offset, fifo2_empty_offset, fifo2_full_offset;
    logic [8:0] next_ae1, next_af1, next_ae2, next_af2, preset;
    logic run1_q, run2_q, rise1, rise2, take1;

    if (DW < 9) begin : g_check
        $error("data width below offset width");
    end

    // ----------------------------------------------------------------
    // offset registers
    // ----------------------------------------------------------------
    always_comb begin
        rise1 = fifo1_reset_n_i && !run1_q;
        rise2 = fifo2_reset_n_i && !run2_q;
        unique case ({offset_select_high_i, offset_select_low_i})
            2'b11: preset = dcf_pkg::PRESET_BOTH;
            2'b10: preset = dcf_pkg::PRESET_HIGH;
            2'b01: preset = dcf_pkg::PRESET_LOW;
            2'b00: preset = dcf_pkg::OFFSET_RESET;
        endcase
        next_ae1 = fifo1_empty_offset;
        next_af1 = fifo1_full_offset;
        next_ae2 = fifo2_empty_offset;
        next_af2 = fifo2_full_offset;
        next_prog = prog;
        if ({offset_select_high_i, offset_select_low_i} != 2'b00) begin
            if (rise1) begin
                {next_ae1, next_af1} = {2{preset}};
            end
            if (rise2) begin
                {next_ae2, next_af2} = {2{preset}};
            end
        end else if (rise1 && rise2) begin
            next_prog = dcf_pkg::PROG_FULL1;
        end
        if (take1) begin
            unique case (prog)
                dcf_pkg::PROG_IDLE: next_prog = dcf_pkg::PROG_IDLE;
                dcf_pkg::PROG_FULL1: next_af1 = port_a_data_i[8:0];
                dcf_pkg::PROG_EMPTY1: next_ae1 = port_a_data_i[8:0];
                dcf_pkg::PROG_FULL2: next_af2 = port_a_data_i[8:0];
                dcf_pkg::PROG_EMPTY2: next_ae2 = port_a_data_i[8:0];
            endcase
            if (prog != dcf_pkg::PROG_IDLE) begin
                next_prog = prog.next(); // four offsets in turn, then back to idle
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run1_q <= 1'b0;
            run2_q <= 1'b0;
            prog <= dcf_pkg::PROG_IDLE;
            fifo1_empty_offset <= dcf_pkg::OFFSET_RESET;
            fifo1_full_offset <= dcf_pkg::OFFSET_RESET;
            fifo2_empty_offset <= dcf_pkg::OFFSET_RESET;
            fifo2_full_offset <= dcf_pkg::OFFSET_RESET;
        end else begin
            run1_q <= fifo1_reset_n_i;
            run2_q <= fifo2_reset_n_i;
            prog <= next_prog;
            fifo1_empty_offset <= next_ae1;
            fifo1_full_offset <= next_af1;
            fifo2_empty_offset <= next_ae2;
            fifo2_full_offset <= next_af2;
        end
    end

    // ----------------------------------------------------------------
    // the two fifos
    // ----------------------------------------------------------------
    dcf_fifo #(.DW(DW), .DEPTH(dcf_pkg::DEPTH)) u_fifo1 (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .run_i(run1_q),
        .wr_tick_i(port_a_clock_i),
        .rd_tick_i(port_b_clock_i),
        .wr_req_i(port_a_write_i),
        .wr_data_i(port_a_data_i),
        .wr_store_i(prog == dcf_pkg::PROG_IDLE),
        .ir_hold_i(1'b0),
        .rd_req_i(port_b_read_i),
        .ae_off_i(fifo1_empty_offset),
        .af_off_i(fifo1_full_offset),
        .rd_data_o(port_b_data_o),
        .flags_o(f1),
        .wr_take_o(take1)
    );

    dcf_fifo #(.DW(DW), .DEPTH(dcf_pkg::DEPTH)) u_fifo2 (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .run_i(run2_q),
        .wr_tick_i(port_b_clock_i),
        .rd_tick_i(port_a_clock_i),
        .wr_req_i(port_b_write_i),
        .wr_data_i(port_b_data_i),
        .wr_store_i(1'b1),
        .ir_hold_i(prog != dcf_pkg::PROG_IDLE),
        .rd_req_i(port_a_read_i),
        .ae_off_i(fifo2_empty_offset),
        .af_off_i(fifo2_full_offset),
        .rd_data_o(port_a_data_o),
        .flags_o(f2),
        .wr_take_o()
    );

    always_comb begin
        port_b_output_ready_o = f1.out_ready;
        port_b_almost_empty_n_o = f1.almost_empty_n;
        port_a_input_ready_o = f1.in_ready;
        port_a_almost_full_n_o = f1.almost_full_n;
        port_a_output_ready_o = f2.out_ready;
        port_a_almost_empty_n_o = f2.almost_empty_n;
        port_b_input_ready_o = f2.in_ready;
        port_b_almost_full_n_o = f2.almost_full_n;
    end
endmodule : dcf_top

// ---- verification/dcf_port_model.sv ----
// free-running port clock source standing for one processor port
`timescale 1ns/1ps

module dcf_port_model (
    input wire logic clock_i,
    input wire logic [3:0] period_i,
    output logic tick_o
);
    logic [3:0] count;

    // ----------------------------------------------------------------
    // one tick every period_i system cycles, moved at the falling edge
    // ----------------------------------------------------------------
    initial begin
        count = 4'h0;
        tick_o = 1'b0;
    end

    always @(negedge clock_i) begin
        if (count + 4'h1 >= period_i) begin
            count <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            count <= count + 4'h1;
            tick_o <= 1'b0;
        end
    end
endmodule : dcf_port_model

// ---- verification/dcf_tb_top.sv ----
// self-checking bench for the dual-clock fifo flag block
`timescale 1ns/1ps

module dcf_tb_top;
    localparam int W = dcf_pkg::DATA_W;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic fifo1_rst_n = 1'b0;
    logic fifo2_rst_n = 1'b0;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b0;
    logic a_wr = 1'b0;
    logic a_rd = 1'b0;
    logic b_wr = 1'b0;
    logic b_rd = 1'b0;
    logic [W-1:0] a_din = '0;
    logic [W-1:0] b_din = '0;
    logic [3:0] a_per = 4'h1;
    logic [3:0] b_per = 4'h1;
    logic a_tick, b_tick, a_or, a_ae_n, a_ir, a_af_n, b_or, b_ae_n, b_ir, b_af_n;
    logic [W-1:0] a_dout, b_dout;
    logic [W-1:0] prog [4] = '{36'h1F0, 36'h2, 36'h0C0, 36'h5};
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    always #25 clock = ~clock;

    dcf_port_model port_a (.clock_i(clock), .period_i(a_per), .tick_o(a_tick));
    dcf_port_model port_b (.clock_i(clock), .period_i(b_per), .tick_o(b_tick));

    dcf_top dut (
        .clock_i(clock), .nrst_i(rst_n), .port_a_clock_i(a_tick), .port_b_clock_i(b_tick),
        .fifo1_reset_n_i(fifo1_rst_n), .fifo2_reset_n_i(fifo2_rst_n),
        .offset_select_low_i(sel_lo), .offset_select_high_i(sel_hi),
        .port_a_write_i(a_wr), .port_a_read_i(a_rd), .port_a_data_i(a_din),
        .port_b_write_i(b_wr), .port_b_read_i(b_rd), .port_b_data_i(b_din),
        .port_a_data_o(a_dout), .port_b_data_o(b_dout),
        .port_a_output_ready_o(a_or), .port_a_almost_empty_n_o(a_ae_n),
        .port_a_input_ready_o(a_ir), .port_a_almost_full_n_o(a_af_n),
        .port_b_output_ready_o(b_or), .port_b_almost_empty_n_o(b_ae_n),
        .port_b_input_ready_o(b_ir), .port_b_almost_full_n_o(b_af_n)
    );

    // ----------------------------------------------------------------
    // compare, access and closing tasks
    // ----------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic print_verdict;
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // request held until an edge that carries the port's tick
    task automatic port_op(input logic side_b, input logic rd, input logic [W-1:0] d);
        @(negedge clock);
        a_din = d;
        b_din = d;
        {a_wr, a_rd, b_wr, b_rd} = {!side_b && !rd, !side_b && rd, side_b && !rd, side_b && rd};
        do @(posedge clock); while (!(side_b ? b_tick : a_tick));
        @(negedge clock);
        {a_wr, a_rd, b_wr, b_rd} = 4'h0;
    endtask : port_op

    task automatic wait_ticks(input logic port_b, input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge clock);
            if (port_b ? b_tick : a_tick) k++;
        end
        #1;
    endtask : wait_ticks

    task automatic reset_fifos(input logic r1, input logic r2, input logic hi, input logic lo);
        @(negedge clock);
        {sel_hi, sel_lo} = {hi, lo};
        fifo1_rst_n = !r1;
        fifo2_rst_n = !r2;
        repeat (2) @(negedge clock);
        fifo1_rst_n = 1'b1;
        fifo2_rst_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : reset_fifos

    // fill to the offset, then cross it with one more write
    task automatic ae_probe(input logic side, input int off);
        for (int k = 0; k <= off; k++) port_op(side, 1'b0, 36'(k) + 36'h100);
        wait_ticks(!side, 4);
        check_bit("almost empty at offset", 1'b0, side ? a_ae_n : b_ae_n);
        port_op(side, 1'b0, 36'h0FF);
        wait_ticks(!side, 1);
        check_bit("almost empty one edge on", 1'b0, side ? a_ae_n : b_ae_n);
        wait_ticks(!side, 1);
        check_bit("almost empty two edges on", 1'b1, side ? a_ae_n : b_ae_n);
    endtask : ae_probe

    task automatic fall_through(input logic side);
        int n;
        logic [W-1:0] d;
        n = 0;
        d = 36'h5A0 ^ 36'(a_per);
        port_op(side, 1'b0, d);
        while (!(side ? a_or : b_or) && n < 12) begin
            @(posedge clock);
            if (side ? a_tick : b_tick) n++;
            #1;
        end
        check_word("reader ticks to output ready", 36'h3, 36'(n));
        check_word("fall-through word", d, side ? a_dout : b_dout);
        port_op(!side, 1'b1, '0);
        wait_ticks(!side, 2);
        check_bit("output ready when empty", 1'b0, side ? a_or : b_or);
        port_op(!side, 1'b1, '0);
        check_word("word after ignored read", d, side ? a_dout : b_dout);
    endtask : fall_through

    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        check_bit("fifo1 output ready", 1'b0, b_or);
        check_bit("fifo1 almost empty", 1'b0, b_ae_n);
        check_bit("fifo1 input ready", 1'b0, a_ir);
        check_bit("fifo1 almost full", 1'b1, a_af_n);
        check_bit("fifo2 input ready", 1'b0, b_ir);
        check_bit("fifo2 almost full", 1'b1, b_af_n);
        check_bit("fifo2 output ready", 1'b0, a_or);
        $display("test reset_state done");
        for (int i = 0; i < 3; i++) begin
            reset_fifos(1'b1, 1'b0, i < 2, i != 1);
            ae_probe(1'b0, i == 0 ? 64 : (i == 1 ? 16 : 8));
        end
        $display("test presets done");
        reset_fifos(1'b1, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            a_per = i[1] ? 4'h3 : 4'h1;
            b_per = i[1] ? 4'h3 : 4'h1;
            fall_through(i[0]);
        end
        a_per = 4'h1;
        b_per = 4'h1;
        $display("test fall_through done");
        reset_fifos(1'b1, 1'b1, 1'b0, 1'b1);
        for (int k = 1; k <= 513; k++) begin
            port_op(1'b0, 1'b0, 36'(k));
            if (k == 504 || k == 505) check_bit("almost full", k == 504, a_af_n);
            if (k >= 512) check_bit("input ready", k == 512, a_ir);
        end
        port_op(1'b0, 1'b0, 36'hFFF);
        check_word("oldest word", 36'h1, b_dout);
        port_op(1'b1, 1'b1, '0);
        wait_ticks(1'b0, 1);
        check_bit("input ready one edge after read", 1'b0, a_ir);
        wait_ticks(1'b0, 1);
        check_bit("input ready two edges after read", 1'b1, a_ir);
        for (int k = 2; k <= 513; k++) begin
            check_word("drained word", 36'(k), b_dout);
            port_op(1'b1, 1'b1, '0);
            if (k == 9) begin
                wait_ticks(1'b0, 1);
                check_bit("almost full one edge on", 1'b0, a_af_n);
                wait_ticks(1'b0, 1);
                check_bit("almost full two edges on", 1'b1, a_af_n);
            end
        end
        wait_ticks(1'b1, 3);
        check_bit("output ready when drained", 1'b0, b_or);
        $display("test full_and_drain done");
        reset_fifos(1'b1, 1'b1, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            check_bit("fifo2 input ready while programming", 1'b0, b_ir);
            port_op(1'b0, 1'b0, prog[k]);
        end
        wait_ticks(1'b1, 3);
        check_bit("fifo2 input ready after programming", 1'b1, b_ir);
        ae_probe(1'b0, 2);
        check_word("first stored word", 36'h100, b_dout);
        for (int k = 1; k <= 13; k++) begin
            port_op(1'b0, 1'b0, 36'(k));
            if (k >= 12) check_bit("programmed almost full", k == 12, a_af_n);
        end
        ae_probe(1'b1, 5);
        for (int k = 1; k <= 314; k++) begin
            port_op(1'b1, 1'b0, 36'(k));
            if (k >= 313) check_bit("fifo2 programmed almost full", k == 313, b_af_n);
        end
        $display("test programming done");
        print_verdict();
    end
endmodule : dcf_tb_top
